// [ext_mem_far_model.sv]
// Purpose: async memory ready behaviour at the far side
// Assumes: ready line has a pull-up, so it idles high
// Notes:   ready drops with the strobe for the wait count; zero never stalls
`timescale 1ns/1ps

module ext_mem_far_model (
   input  wire       i_sys_clk,
   input  wire       i_rst,
   input  wire       i_strobe_n,
   input  wire [3:0] i_wait_cyc,
   output wire       o_async_ready
);
   reg [3:0] cnt_r;
   // ready falls with the strobe, else the two sync flops in the
   // design would hide it until the strobe count has run out
   assign o_async_ready = i_strobe_n | (cnt_r >= i_wait_cyc);
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst)
         cnt_r <= 4'h0;
      else if (i_strobe_n)
         cnt_r <= 4'h0;
      else if (cnt_r != 4'hf)
         cnt_r <= cnt_r + 4'h1;
   end
endmodule // ext_mem_far_model

// [ext_mem_pin_control.v]
// Purpose: pin-level control of a 16-bit external memory port
// Assumes: access requests come from logic on i_sys_clk
// Notes:   address and data pins are handled elsewhere
//
// Operation
// - the space select to drive is decoded from word-address bits 31..28.
// - at most one space select is active during any access.
// - byte-lane enables are decoded from the access size and the lowest address bit.
// - byte-lane enables act as byte write enables and as sdram data mask.
// - memory clock comes from the core clock when the select is 0, else pin.
// - memory clock is held low when its enable is 0 and runs when it is 1.
// - the read strobe pin is async read, sdram cas and sbsram address strobe.
// - the output enable pin is async oe, sdram ras and sbsram output enable.
// - the write strobe pin is the write enable for every memory type.
// - a host asks for the bus by hold request and is answered by hold ack.
`timescale 1ns/1ps
`include "ext_mem_pin_regs.vh"

module ext_mem_pin_control (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_acc_req,
   input  wire [31:0] i_acc_addr,
   input  wire        i_acc_write,
   input  wire [1:0]  i_acc_size,
   input  wire [1:0]  i_acc_type,
   output wire        o_acc_ack,
   output wire        o_acc_unmapped,
   input  wire        i_async_ready_in,
   input  wire        i_hold_req,
   output wire        o_ext_bus_hold_ack,
   output wire        o_bus_request_out,
   output wire [3:0]  o_space_select_n,
   output wire [1:0]  o_byte_lane_enable_n,
   output wire        o_read_strobe_pin_n,
   output wire        o_output_enable_pin_n,
   output wire        o_write_strobe_pin_n,
   output wire        o_pins_oe,
   input  wire        i_mem_clk_in,
   input  wire        i_mem_clk_source_sel,
   input  wire        i_mem_clk_out_enable,
   output wire        o_mem_clk_out
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_SETUP  = 3'h1;
   localparam [2:0] ST_STROBE = 3'h2;
   localparam [2:0] ST_HOLDP  = 3'h3;
   localparam [2:0] ST_SD_ACT = 3'h4;
   localparam [2:0] ST_SD_CMD = 3'h5;
   localparam [2:0] ST_SB     = 3'h6;
   localparam [2:0] ST_GRANT  = 3'h7;

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function [3:0] space_onehot;
      input [3:0] code;
      begin
         space_onehot = 4'h0;
         case (code)
            `SPACE_CODE_0: space_onehot = 4'h1;
            `SPACE_CODE_1: space_onehot = 4'h2;
            `SPACE_CODE_2: space_onehot = 4'h4;
            `SPACE_CODE_3: space_onehot = 4'h8;
            default:       space_onehot = 4'h0;
         endcase
      end
   endfunction

   // active-high lanes; a word is one 16-bit beat on this bus
   function [1:0] byte_lanes;
      input [1:0] addr_lo;
      input [1:0] size;
      begin
         byte_lanes = 2'h3;
         if (size == `SIZE_BYTE) begin
            if (addr_lo[0])
               byte_lanes = 2'h2;
            else
               byte_lanes = 2'h1;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   reg rdy_meta_r;
   reg rdy_sync_r;
   reg hold_meta_r;
   reg hold_sync_r;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdy_meta_r  <= 1'b0;
         rdy_sync_r  <= 1'b0;
         hold_meta_r <= 1'b0;
         hold_sync_r <= 1'b0;
      end else begin
         rdy_meta_r  <= i_async_ready_in;
         rdy_sync_r  <= rdy_meta_r;
         hold_meta_r <= i_hold_req;
         hold_sync_r <= hold_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] cnt_r;
   reg [3:0] cnt_nxt;
   reg [3:0] sel_r;
   reg [3:0] sel_nxt;
   reg [1:0] lanes_r;
   reg [1:0] lanes_nxt;
   reg       wr_r;
   reg       wr_nxt;
   reg       ack_nxt;
   reg       unmapped_nxt;
   reg [3:0] dec_sel;

   always @* begin
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      sel_nxt      = sel_r;
      lanes_nxt    = lanes_r;
      wr_nxt       = wr_r;
      ack_nxt      = 1'b0;
      unmapped_nxt = 1'b0;
      dec_sel      = space_onehot(
                        i_acc_addr[`SPACE_MSB:`SPACE_LSB]);
      case (state_r)
         ST_IDLE: begin
            if (hold_sync_r) begin
               // host wins over a new access between transfers
               state_nxt = ST_GRANT;
            end else if (i_acc_req) begin
               if (dec_sel == 4'h0) begin
                  ack_nxt      = 1'b1;
                  unmapped_nxt = 1'b1;
               end else begin
                  sel_nxt   = dec_sel;
                  lanes_nxt = byte_lanes(i_acc_addr[1:0],
                                         i_acc_size);
                  wr_nxt    = i_acc_write;
                  case (i_acc_type)
                     `MTYPE_SDRAM: begin
                        state_nxt = ST_SD_ACT;
                     end
                     `MTYPE_SBSRAM: begin
                        state_nxt = ST_SB;
                        cnt_nxt   = `SBS_ADS_CYC;
                     end
                     default: begin
                        state_nxt = ST_SETUP;
                        cnt_nxt   = `ASYNC_SETUP_CYC - 4'h1;
                     end
                  endcase
               end
            end
         end
         ST_SETUP: begin
            if (cnt_r == 4'h0) begin
               state_nxt = ST_STROBE;
               cnt_nxt   = `ASYNC_STROBE_CYC - 4'h1;
            end else begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         ST_STROBE: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (rdy_sync_r) begin
               state_nxt = ST_HOLDP;
               cnt_nxt   = `ASYNC_HOLD_CYC - 4'h1;
            end
         end
         ST_HOLDP: begin
            if (cnt_r == 4'h0) begin
               state_nxt = ST_IDLE;
               sel_nxt   = 4'h0;
               ack_nxt   = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         ST_SD_ACT: begin
            state_nxt = ST_SD_CMD;
         end
         ST_SD_CMD: begin
            state_nxt = ST_IDLE;
            sel_nxt   = 4'h0;
            ack_nxt   = 1'b1;
         end
         ST_SB: begin
            // writes end after the address strobe
            if (cnt_r == 4'h0 || wr_r) begin
               state_nxt = ST_IDLE;
               sel_nxt   = 4'h0;
               ack_nxt   = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         ST_GRANT: begin
            if (!hold_sync_r)
               state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            sel_nxt   = 4'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // strobe pin roles per next state
   // ----------------------------------------------------------------
   reg re_nxt;
   reg oe_nxt;
   reg we_nxt;

   always @* begin
      re_nxt = 1'b0;
      oe_nxt = 1'b0;
      we_nxt = 1'b0;
      case (state_nxt)
         ST_SETUP: begin
            oe_nxt = ~wr_nxt;
         end
         ST_STROBE: begin
            oe_nxt = ~wr_nxt;
            re_nxt = ~wr_nxt;
            we_nxt = wr_nxt;
         end
         ST_SD_ACT: begin
            oe_nxt = 1'b1;
         end
         ST_SD_CMD: begin
            re_nxt = 1'b1;
            we_nxt = wr_nxt;
         end
         ST_SB: begin
            re_nxt = (cnt_nxt == `SBS_ADS_CYC);
            we_nxt = wr_nxt;
            oe_nxt = ~wr_nxt & (cnt_nxt != `SBS_ADS_CYC);
         end
         default: begin
            re_nxt = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registered pins
   // ----------------------------------------------------------------
   reg [3:0] sel_n_r;
   reg [1:0] lanes_n_r;
   reg       re_n_r;
   reg       oe_n_r;
   reg       we_n_r;
   reg       ack_r;
   reg       unmapped_r;
   reg       hold_ack_r;
   reg       bus_request_out_r;
   reg       pins_oe_r;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r    <= ST_IDLE;
         cnt_r      <= 4'h0;
         sel_r      <= 4'h0;
         lanes_r    <= 2'h0;
         wr_r       <= 1'b0;
         sel_n_r    <= 4'hf;
         lanes_n_r  <= 2'h3;
         re_n_r     <= 1'b1;
         oe_n_r     <= 1'b1;
         we_n_r     <= 1'b1;
         ack_r      <= 1'b0;
         unmapped_r <= 1'b0;
         hold_ack_r <= 1'b0;
         bus_request_out_r   <= 1'b0;
         pins_oe_r  <= 1'b1;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         sel_r      <= sel_nxt;
         lanes_r    <= lanes_nxt;
         wr_r       <= wr_nxt;
         sel_n_r    <= ~sel_nxt;
         // lanes enabled only while a space is selected
         lanes_n_r  <= (sel_nxt != 4'h0) ? ~lanes_nxt
                                         : 2'h3;
         re_n_r     <= ~re_nxt;
         oe_n_r     <= ~oe_nxt;
         we_n_r     <= ~we_nxt;
         ack_r      <= ack_nxt;
         unmapped_r <= unmapped_nxt;
         hold_ack_r <= (state_nxt == ST_GRANT);
         bus_request_out_r   <= (state_nxt == ST_GRANT) & i_acc_req;
         // pins float while the host owns the bus
         pins_oe_r  <= (state_nxt != ST_GRANT);
      end
   end

   assign o_acc_ack             = ack_r;
   assign o_acc_unmapped        = unmapped_r;
   assign o_ext_bus_hold_ack    = hold_ack_r;
   assign o_bus_request_out     = bus_request_out_r;
   assign o_space_select_n      = sel_n_r;
   assign o_byte_lane_enable_n  = lanes_n_r;
   assign o_read_strobe_pin_n   = re_n_r;
   assign o_output_enable_pin_n = oe_n_r;
   assign o_write_strobe_pin_n  = we_n_r;
   assign o_pins_oe             = pins_oe_r;

   // ----------------------------------------------------------------
   // memory clock
   // ----------------------------------------------------------------
   mem_clk_select mem_clk_select_inst (
      .i_sys_clk            (i_sys_clk),
      .i_rst                (i_rst),
      .i_mem_clk_in         (i_mem_clk_in),
      .i_mem_clk_source_sel (i_mem_clk_source_sel),
      .i_mem_clk_out_enable (i_mem_clk_out_enable),
      .o_mem_clk_out        (o_mem_clk_out)
   );

endmodule // ext_mem_pin_control

// [ext_mem_pin_control_props.sv]
// Purpose: concurrent checks on the external memory pin control ports
// Assumes: request fields are held until ack, as the port demands
// Notes:   the core clock check waits three edges after reset for the divider
`timescale 1ns/1ps
`include "ext_mem_pin_regs.vh"

module ext_mem_pin_control_props (
   input wire        i_sys_clk,
   input wire        i_rst,
   input wire        i_acc_req,
   input wire [31:0] i_acc_addr,
   input wire        i_acc_write,
   input wire [1:0]  i_acc_size,
   input wire [1:0]  i_acc_type,
   input wire        o_acc_ack,
   input wire        i_async_ready_in,
   input wire        i_hold_req,
   input wire        o_ext_bus_hold_ack,
   input wire [3:0]  o_space_select_n,
   input wire [1:0]  o_byte_lane_enable_n,
   input wire        o_read_strobe_pin_n,
   input wire        o_output_enable_pin_n,
   input wire        o_write_strobe_pin_n,
   input wire        o_pins_oe,
   input wire        i_mem_clk_source_sel,
   input wire        i_mem_clk_out_enable,
   input wire        o_mem_clk_out
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   reg  [1:0] age_r;
   wire       sel_any = (o_space_select_n != 4'hf);
   wire       strb    = !(o_read_strobe_pin_n && o_write_strobe_pin_n);
   wire       is_asyn = (i_acc_type != `MTYPE_SDRAM) &&
                        (i_acc_type != `MTYPE_SBSRAM);
   wire [3:0] sel_exp = ~(4'h1 << i_acc_addr[29:28]);
   wire [1:0] ln_exp  = (i_acc_size == `SIZE_BYTE) ?
                        ~(2'h1 << i_acc_addr[0]) : 2'h0;
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst)
         age_r <= 2'h0;
      else if (age_r != 2'h3)
         age_r <= age_r + 2'h1;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence ras_then_cas;
      !o_output_enable_pin_n ##1
      (o_output_enable_pin_n && !o_read_strobe_pin_n) ##1 o_acc_ack;
   endsequence
   sequence ads_with_write;
      (!o_read_strobe_pin_n && !o_write_strobe_pin_n) ##1 o_acc_ack;
   endsequence

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   one_select_a: assert property ($onehot0(~o_space_select_n))
      else $error("more than one space select active");
   space_decode_a: assert property (sel_any |->
      i_acc_addr[31:30] == 2'h2 && o_space_select_n == sel_exp)
      else $error("space select does not match address code");
   lane_decode_a: assert property (sel_any |->
      o_byte_lane_enable_n == ln_exp)
      else $error("lane enables do not match size and address");
   lane_idle_a: assert property (!sel_any |->
      o_byte_lane_enable_n == 2'h3)
      else $error("lane enable active outside an access");
   clk_gate_a: assert property (!$past(i_mem_clk_out_enable)
      |-> !o_mem_clk_out) else $error("gated memory clock not low");
   clk_core_a: assert property (age_r == 2'h3 &&
      $past(i_mem_clk_out_enable) && $past(i_mem_clk_out_enable, 2) &&
      !$past(i_mem_clk_source_sel) && !$past(i_mem_clk_source_sel, 2)
      |-> o_mem_clk_out != $past(o_mem_clk_out))
      else $error("core memory clock not toggling");
   hold_grant_a: assert property (o_ext_bus_hold_ack |->
      !o_pins_oe && !sel_any && !o_acc_ack)
      else $error("pins driven while bus granted");
   hold_rise_a: assert property ($rose(o_ext_bus_hold_ack) |->
      $past(i_hold_req, 2)) else $error("grant without hold request");
   ready_wait_a: assert property (is_asyn && strb &&
      !i_async_ready_in && !$past(i_async_ready_in) &&
      !$past(i_async_ready_in, 2) |=> strb)
      else $error("async strobe ended while not ready");
   sdram_seq_a: assert property ($rose(sel_any) &&
      i_acc_type == `MTYPE_SDRAM |-> ras_then_cas)
      else $error("sdram strobe order wrong");
   sbs_write_a: assert property ($rose(sel_any) && i_acc_write &&
      i_acc_type == `MTYPE_SBSRAM |-> ads_with_write)
      else $error("sbsram write strobes wrong");
endmodule // ext_mem_pin_control_props

bind ext_mem_pin_control ext_mem_pin_control_props props_inst (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_acc_req(i_acc_req),
   .i_acc_addr(i_acc_addr), .i_acc_write(i_acc_write),
   .i_acc_size(i_acc_size), .i_acc_type(i_acc_type),
   .o_acc_ack(o_acc_ack), .i_async_ready_in(i_async_ready_in),
   .i_hold_req(i_hold_req), .o_ext_bus_hold_ack(o_ext_bus_hold_ack),
   .o_space_select_n(o_space_select_n),
   .o_byte_lane_enable_n(o_byte_lane_enable_n),
   .o_read_strobe_pin_n(o_read_strobe_pin_n),
   .o_output_enable_pin_n(o_output_enable_pin_n),
   .o_write_strobe_pin_n(o_write_strobe_pin_n), .o_pins_oe(o_pins_oe),
   .i_mem_clk_source_sel(i_mem_clk_source_sel),
   .i_mem_clk_out_enable(i_mem_clk_out_enable),
   .o_mem_clk_out(o_mem_clk_out));

// [ext_mem_pin_control_tb_top.sv]
// Purpose: self-checking bench for the external memory pin control
// Assumes: far model supplies async ready
// Notes:   req drops at the negedge of the ack cycle, else it is retaken
`timescale 1ns/1ps

module ext_mem_pin_control_tb_top;
   typedef struct packed {
      logic [31:0] addr;
      logic        wr;
      logic [1:0]  size;
      logic [1:0]  typ;
      logic [3:0]  sel;
      logic [1:0]  lane;
      logic [7:0]  lat;
      logic [3:0]  str;
   } row_t;
   reg        i_sys_clk = 1'b0, i_rst = 1'b1, i_acc_req = 1'b0;
   reg        i_acc_write = 1'b0, i_hold_req = 1'b0, i_mem_clk_in = 1'b0;
   reg        i_mem_clk_source_sel = 1'b0, i_mem_clk_out_enable = 1'b1;
   reg [31:0] i_acc_addr = 32'h0;
   reg [1:0]  i_acc_size = 2'h0, i_acc_type = 2'h0;
   reg [3:0]  wait_cyc = 4'h0, sel;
   reg [1:0]  lane;
   reg [3:0]  str;
   reg [7:0]  lat;
   reg        breq, prev;
   wire       o_acc_ack, o_acc_unmapped, o_ext_bus_hold_ack, o_pins_oe;
   wire       o_bus_request_out, o_mem_clk_out, ready;
   wire       o_read_strobe_pin_n, o_output_enable_pin_n, o_write_strobe_pin_n;
   wire [3:0] o_space_select_n;
   wire [1:0] o_byte_lane_enable_n;
   integer    error_cnt = 0, check_count = 0, i, cnt;
   row_t      rows [0:7];
   wire [12:0] pin_vec = {o_space_select_n, o_byte_lane_enable_n,
      o_read_strobe_pin_n, o_output_enable_pin_n, o_write_strobe_pin_n,
      o_pins_oe, o_mem_clk_out, o_acc_ack, o_ext_bus_hold_ack};

   always #10 i_sys_clk = ~i_sys_clk;
   always #80 i_mem_clk_in = ~i_mem_clk_in;

   ext_mem_pin_control ext_mem_pin_control_inst (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_acc_req(i_acc_req),
      .i_acc_addr(i_acc_addr), .i_acc_write(i_acc_write),
      .i_acc_size(i_acc_size), .i_acc_type(i_acc_type),
      .o_acc_ack(o_acc_ack), .o_acc_unmapped(o_acc_unmapped),
      .i_async_ready_in(ready), .i_hold_req(i_hold_req),
      .o_ext_bus_hold_ack(o_ext_bus_hold_ack),
      .o_bus_request_out(o_bus_request_out),
      .o_space_select_n(o_space_select_n),
      .o_byte_lane_enable_n(o_byte_lane_enable_n),
      .o_read_strobe_pin_n(o_read_strobe_pin_n),
      .o_output_enable_pin_n(o_output_enable_pin_n),
      .o_write_strobe_pin_n(o_write_strobe_pin_n), .o_pins_oe(o_pins_oe),
      .i_mem_clk_in(i_mem_clk_in),
      .i_mem_clk_source_sel(i_mem_clk_source_sel),
      .i_mem_clk_out_enable(i_mem_clk_out_enable),
      .o_mem_clk_out(o_mem_clk_out));

   ext_mem_far_model ext_mem_far_model_inst (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_strobe_n(o_read_strobe_pin_n & o_write_strobe_pin_n),
      .i_wait_cyc(wait_cyc), .o_async_ready(ready));

   task check(input [15:0] seen, input [15:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task print_verdict;
      begin
         if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   // one access; rel releases the hold request at that negedge
   task automatic run(input row_t r, input integer rel);
      integer n;
      reg     done;
      begin
         sel = 4'hf;
         lane = 2'h3;
         str = 4'h0;
         lat = 8'hff;
         done = 1'b0;
         @(posedge i_sys_clk);
         i_acc_req <= 1'b1;
         i_acc_addr <= r.addr;
         i_acc_write <= r.wr;
         i_acc_size <= r.size;
         i_acc_type <= r.typ;
         for (n = 1; n < 60 && !done; n = n + 1) begin
            @(negedge i_sys_clk);
            if (n == 4)
               breq = o_bus_request_out;
            if (n == rel)
               i_hold_req <= 1'b0;
            if (o_space_select_n !== 4'hf && sel === 4'hf) begin
               sel = o_space_select_n;
               lane = o_byte_lane_enable_n;
            end
            str = str | {1'b0, ~o_read_strobe_pin_n,
               ~o_output_enable_pin_n, ~o_write_strobe_pin_n};
            if (o_acc_ack === 1'b1) begin
               str = str | {o_acc_unmapped, 3'h0};
               lat = n - 1;
               done = 1'b1;
               i_acc_req <= 1'b0;
            end
         end
      end
   endtask

   task count_toggles(input integer n);
      begin
         repeat (4) @(negedge i_sys_clk);
         prev = o_mem_clk_out;
         cnt = 0;
         repeat (n) begin
            @(negedge i_sys_clk);
            if (o_mem_clk_out !== prev)
               cnt = cnt + 1;
            prev = o_mem_clk_out;
         end
      end
   endtask

   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      print_verdict;
   end

   initial begin
      rows[0] = {32'h80000000, 1'b0, 2'h0, 2'h0, 4'he, 2'h2, 8'h7, 4'h6};
      rows[1] = {32'h90000001, 1'b1, 2'h0, 2'h0, 4'hd, 2'h1, 8'h7, 4'h1};
      rows[2] = {32'ha0000002, 1'b0, 2'h1, 2'h1, 4'hb, 2'h0, 8'h3, 4'h6};
      rows[3] = {32'hb0000000, 1'b1, 2'h2, 2'h1, 4'h7, 2'h0, 8'h3, 4'h7};
      rows[4] = {32'h80000003, 1'b0, 2'h0, 2'h2, 4'he, 2'h1, 8'h3, 4'h6};
      rows[5] = {32'h90000002, 1'b1, 2'h1, 2'h2, 4'hd, 2'h0, 8'h2, 4'h5};
      rows[6] = {32'h00000000, 1'b0, 2'h0, 2'h0, 4'hf, 2'h3, 8'h1, 4'h8};
      rows[7] = {32'ha0000000, 1'b1, 2'h0, 2'h3, 4'hb, 2'h2, 8'h7, 4'h1};
      @(negedge i_sys_clk);
      check(pin_vec, 13'h1ff8);
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         run(rows[i], 0);
         check(sel, rows[i].sel);
         check(lane, rows[i].lane);
         check(str, rows[i].str);
         check(lat, rows[i].lat);
      end
      wait_cyc <= 4'h6;
      run(rows[0], 0);
      check(lat >= 8'd10 && lat <= 8'd16, 1'b1);
      wait_cyc <= 4'h0;
      @(posedge i_sys_clk);
      i_hold_req <= 1'b1;
      repeat (5) @(negedge i_sys_clk);
      check({o_ext_bus_hold_ack, o_pins_oe, o_space_select_n}, 6'h2f);
      run(rows[1], 6);
      check(breq, 1'b1);
      check(lat >= 8'd12 && lat <= 8'd18, 1'b1);
      check({o_ext_bus_hold_ack, sel}, 5'h0d);
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      @(negedge i_sys_clk);
      check(pin_vec, 13'h1ff8);
      i_rst <= 1'b0;
      count_toggles(20);
      check(cnt, 20);
      i_mem_clk_source_sel <= 1'b1;
      count_toggles(80);
      check(cnt >= 19 && cnt <= 21, 1'b1);
      i_mem_clk_out_enable <= 1'b0;
      count_toggles(20);
      check({cnt, o_mem_clk_out}, 1'b0);
      print_verdict;
   end
endmodule // ext_mem_pin_control_tb_top

// [ext_mem_pin_regs.vh]
// Purpose: constants for the external memory port pin control
// Assumes: plain Verilog-2005, included by bare name
// Notes:   all counts are in cycles of i_sys_clk (50 MHz)
`ifndef EXT_MEM_PIN_REGS_VH
`define EXT_MEM_PIN_REGS_VH

// ----------------------------------------------------------------
// chip-space codes, word-address bits 31..28
// ----------------------------------------------------------------
`define SPACE_CODE_0      4'h8
`define SPACE_CODE_1      4'h9
`define SPACE_CODE_2      4'ha
`define SPACE_CODE_3      4'hb
`define SPACE_MSB         31
`define SPACE_LSB         28

// ----------------------------------------------------------------
// memory types and access sizes
// ----------------------------------------------------------------
`define MTYPE_ASYNC       2'h0
`define MTYPE_SDRAM       2'h1
`define MTYPE_SBSRAM      2'h2
`define SIZE_BYTE         2'h0
`define SIZE_HALF         2'h1
`define SIZE_WORD         2'h2

// ----------------------------------------------------------------
// asynchronous access phases and sbsram address strobe, in cycles
// ----------------------------------------------------------------
`define ASYNC_SETUP_CYC   4'h2
`define ASYNC_STROBE_CYC  4'h3
`define ASYNC_HOLD_CYC    4'h1
`define SBS_ADS_CYC       4'h1

// ----------------------------------------------------------------
// memory clock
// ----------------------------------------------------------------
`define MCLK_SRC_CORE     1'b0
`define MCLK_SRC_PIN      1'b1
`define MCLK_SRC_RST      1'b0
`define MCLK_EN_RST       1'b1

`endif

// [mem_clk_select.v]
// Purpose: memory clock output source select and gating
// Assumes: i_mem_clk_in is far slower than i_sys_clk
// Notes:   output is a sampled copy, so it carries sys-clock jitter
`timescale 1ns/1ps
`include "ext_mem_pin_regs.vh"

module mem_clk_select (
   input  wire i_sys_clk,
   input  wire i_rst,
   input  wire i_mem_clk_in,
   input  wire i_mem_clk_source_sel,
   input  wire i_mem_clk_out_enable,
   output wire o_mem_clk_out
);

   // ----------------------------------------------------------------
   // pin synchroniser and core derived clock
   // ----------------------------------------------------------------
   reg mclk_meta_r;
   reg mclk_sync_r;
   reg core_derived_clock_r;
   reg mem_clk_out_r;
   reg mem_clk_out_nxt;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mclk_meta_r          <= 1'b0;
         mclk_sync_r          <= 1'b0;
         core_derived_clock_r <= 1'b0;
         mem_clk_out_r        <= 1'b0;
      end else begin
         mclk_meta_r          <= i_mem_clk_in;
         mclk_sync_r          <= mclk_meta_r;
         // sys clock divided by two
         core_derived_clock_r <= ~core_derived_clock_r;
         mem_clk_out_r        <= mem_clk_out_nxt;
      end
   end

   // ----------------------------------------------------------------
   // source select and gate
   // ----------------------------------------------------------------
   always @* begin
      mem_clk_out_nxt = 1'b0;
      if (i_mem_clk_out_enable) begin
         if (i_mem_clk_source_sel == `MCLK_SRC_PIN)
            mem_clk_out_nxt = mclk_sync_r;
         else
            mem_clk_out_nxt = core_derived_clock_r;
      end
   end

   assign o_mem_clk_out = mem_clk_out_r;

endmodule // mem_clk_select
